// *** core/wit_defs.svh ***
`ifndef WIT_DEFS_SVH
`define WIT_DEFS_SVH

`define WIT_ADDR_W          4
`define WIT_OFS_TIME        4'h0
`define WIT_OFS_MODE        4'h1
`define WIT_OFS_IRQ_CTRL    4'h2
`define WIT_OFS_STATUS      4'h3

`define WIT_MODE_RUN_BIT    7
`define WIT_MODE_SEL_BIT    4
`define WIT_MODE_ACT_BIT    3
`define WIT_IRQ_MASK_BIT    6
`define WIT_TIME_RST        8'h00
`define WIT_MODE_RST        8'h00
`define WIT_IRQ_CTRL_RST    8'h47

`define WIT_CNT_W           21

`endif

// *** core/wit_pkg.sv ***
package wit_pkg;
    typedef enum logic [2:0] {
        WIT_ST_IDLE   = 3'b001,
        WIT_ST_ITVL   = 3'b010,
        WIT_ST_WDOG   = 3'b100
    } wit_state_t;

    typedef enum logic [1:0] {
        WIT_ACT_ITVL0 = 2'b00,
        WIT_ACT_ITVL1 = 2'b01,
        WIT_ACT_NMI   = 2'b10,
        WIT_ACT_RESET = 2'b11
    } wit_mode_t;
endpackage

// *** core/wit_prescaler.sv ***
`timescale 1ns/1ps
`include "wit_defs.svh"
module wit_prescaler
    import wit_pkg::*;
#(
    parameter int CNT_W = `WIT_CNT_W
) (
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             clear_i,
    input  wire logic             count_en_i,
    input  wire logic [2:0]       sel_i,
    output logic                  ovf_o,
    output logic [CNT_W-1:0]      count_o
);
    // Top tap sits at bit 20
    if (CNT_W < 21) begin : g_cnt_w_check
        $error("wit_prescaler: CNT_W below 21");
    end

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W:0]   sum;
    logic [4:0]       stage;
    logic             tap_old;
    logic             tap_new;
    logic             ovf_q;

    // Stage index: 13..19, then 21 for the top code
    assign stage   = (sel_i == 3'h7) ? 5'd21 : 5'(5'd13 + {2'b00, sel_i}); // RL2
    assign sum     = {1'b0, cnt_q} + {{CNT_W{1'b0}}, 1'b1};
    assign tap_old = cnt_q[stage - 5'd1];
    assign tap_new = sum[stage - 5'd1];
    assign cnt_d   = clear_i ? '0 : (count_en_i ? sum[CNT_W-1:0] : cnt_q);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= '0;
            ovf_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            ovf_q <= !clear_i && count_en_i && tap_old && !tap_new; // RL19
        end
    end

    assign ovf_o   = ovf_q;
    assign count_o = cnt_q;
endmodule

// *** core/wit_sync.sv ***
`timescale 1ns/1ps
module wit_sync (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic s1_q;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_q <= 1'b0;
            q_o  <= 1'b0;
        end else begin
            s1_q <= d_i;
            q_o  <= s1_q;
        end
    end
endmodule

// *** core/wit_top.sv ***
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "wit_defs.svh"
// Functional notes
// RL1 - Mode select bit at 1 selects program-loop watchdog operation.
// RL2 - Three-bit time select gives period 2^13..2^19 or 2^21 clocks.
// RL3 - Writing 1 to the run bit starts counting.
// RL4 - Each later run-bit write of 1 clears counter and restarts it.
// RL5 - Watchdog overflow raises reset if action bit set, else NMI.
// RL6 - Watchdog counting halts in STOP or IDLE.
// RL7 - Software should write run bit just before STOP or IDLE.
// RL8 - Watchdog keeps counting during HALT.
// RL9 - Counter holds its value while CPU runs from subclock.
// RL10 - Mode select 0 gives interval timer with periodic maskable request.
// RL11 - Interval request gated by mask flag, carries three-bit priority.
// RL12 - Interval request has highest default maskable priority.
// RL13 - Interval counting continues in HALT, stops in STOP and IDLE.
// RL14 - Once watchdog selected, interval mode cannot return until reset.
// RL15 - Mode 00/01 interval, 10 watchdog NMI, 11 watchdog reset.
// RL16 - Run bit cannot be cleared by software once set.
// RL17 - Mode and action bits cannot be cleared by software once set.
// RL18 - Reset clears mode register: counter stopped, interval mode.
// RL19 - Binary prescaler; rollover of selected stage gives one-cycle pulse.
// RL20 - Power-stop and subclock inputs gate the count enable.
module wit_top
    import wit_pkg::*;
#(
    parameter int CNT_W = `WIT_CNT_W
) (
    input  wire logic                   clk_i,
    input  wire logic                   nrst_i,
    input  wire logic [`WIT_ADDR_W-1:0] addr_i,
    input  wire logic [7:0]             wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [7:0]             rdata_o,
    input  wire logic                   halt_mode_i,
    input  wire logic                   stop_idle_mode_i,
    input  wire logic                   subclock_sel_i,
    output logic                        wd_reset_request_o,
    output logic                        wd_nmi_request_o,
    output logic                        interval_irq_request_o,
    output logic      [2:0]             interval_irq_priority_o,
    output logic                        interval_irq_default_top_o
);
    // Top tap sits at bit 20
    if (CNT_W < 21) begin : g_cnt_w_check
        $error("wit_top: CNT_W below 21");
    end

    logic [2:0]       overflow_time_register_q;
    logic             count_run_bit_q;
    logic             wd_mode_select_bit_q;
    logic             overflow_action_bit_q;
    logic             interval_irq_mask_q;
    logic [2:0]       interval_irq_priority_q;
    logic             nmi_q;
    logic             rst_q;
    logic             itv_q;
    logic [7:0]       rdata_q;
    logic             ovf_seen_q;

    logic             stop_idle_s;
    logic             subclock_s;
    logic             ovf;
    logic [CNT_W-1:0] count;
    logic             wr_time;
    logic             wr_mode;
    logic             wr_irq;
    logic             restart;
    logic             count_en;
    logic [7:0]       mode_rd;
    logic [7:0]       irq_rd;
    logic [7:0]       stat_rd;
    logic [7:0]       rd_mux;
    wit_mode_t        mode;
    wit_state_t       state;

    wit_sync u_sync_stop (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    (stop_idle_mode_i),
        .q_o    (stop_idle_s)
    );

    wit_sync u_sync_sub (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    (subclock_sel_i),
        .q_o    (subclock_s)
    );

    // Register decode
    assign wr_time = wr_i && (addr_i == `WIT_OFS_TIME);
    assign wr_mode = wr_i && (addr_i == `WIT_OFS_MODE);
    assign wr_irq  = wr_i && (addr_i == `WIT_OFS_IRQ_CTRL);
    assign restart = wr_mode && wdata_i[`WIT_MODE_RUN_BIT]; // RL3 RL4

    // HALT does not gate the count
    assign count_en = count_run_bit_q && !stop_idle_s && !subclock_s; // RL6 RL8 RL9 RL13 RL20

    assign mode  = wit_mode_t'({wd_mode_select_bit_q, overflow_action_bit_q});
    assign state = !count_run_bit_q ? WIT_ST_IDLE
                 : (wd_mode_select_bit_q ? WIT_ST_WDOG : WIT_ST_ITVL); // RL1 RL10 RL15

    wit_prescaler #(
        .CNT_W (CNT_W)
    ) u_presc (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .clear_i    (restart),
        .count_en_i (count_en),
        .sel_i      (overflow_time_register_q),
        .ovf_o      (ovf),
        .count_o    (count)
    ); // RL2 RL19

    assign mode_rd = {count_run_bit_q, 2'b00, wd_mode_select_bit_q, overflow_action_bit_q, 3'b000};
    assign irq_rd  = {1'b0, interval_irq_mask_q, 3'b000, interval_irq_priority_q};
    assign stat_rd = {3'b000, ovf_seen_q, 1'b0, state};
    assign rd_mux  = (addr_i == `WIT_OFS_TIME)     ? {5'b00000, overflow_time_register_q}
                   : (addr_i == `WIT_OFS_MODE)     ? mode_rd
                   : (addr_i == `WIT_OFS_IRQ_CTRL) ? irq_rd
                   : (addr_i == `WIT_OFS_STATUS)   ? stat_rd
                   : 8'h00;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            overflow_time_register_q <= 3'h0;
            count_run_bit_q          <= 1'b0;
            wd_mode_select_bit_q     <= 1'b0;
            overflow_action_bit_q    <= 1'b0; // RL18
        end else begin
            if (wr_time) begin
                overflow_time_register_q <= wdata_i[2:0];
            end
            if (wr_mode) begin
                // Bits are sticky: software can only set them
                count_run_bit_q       <= count_run_bit_q | wdata_i[`WIT_MODE_RUN_BIT]; // RL16
                wd_mode_select_bit_q  <= wd_mode_select_bit_q | wdata_i[`WIT_MODE_SEL_BIT]; // RL14 RL17
                overflow_action_bit_q <= overflow_action_bit_q | wdata_i[`WIT_MODE_ACT_BIT]; // RL17
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            interval_irq_mask_q     <= 1'b1;
            interval_irq_priority_q <= 3'h7;
        end else if (wr_irq) begin
            interval_irq_mask_q     <= wdata_i[`WIT_IRQ_MASK_BIT];
            interval_irq_priority_q <= wdata_i[2:0];
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            nmi_q <= 1'b0;
            rst_q <= 1'b0;
            itv_q <= 1'b0;
        end else begin
            nmi_q <= ovf && (mode == WIT_ACT_NMI); // RL5
            rst_q <= ovf && (mode == WIT_ACT_RESET); // RL5
            itv_q <= ovf && !wd_mode_select_bit_q && !interval_irq_mask_q; // RL10 RL11
        end
    end

    // Overflow seen flag: set wins over read-clear
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ovf_seen_q <= 1'b0;
        end else if (ovf) begin
            ovf_seen_q <= 1'b1;
        end else if (rd_i && addr_i == `WIT_OFS_STATUS) begin
            ovf_seen_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= 8'h00;
        end else if (rd_i) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata_o                    = rdata_q;
    assign wd_nmi_request_o           = nmi_q;
    assign wd_reset_request_o         = rst_q;
    assign interval_irq_request_o     = itv_q;
    assign interval_irq_priority_o    = interval_irq_priority_q; // RL11
    assign interval_irq_default_top_o = 1'b1; // RL12
endmodule

// *** sim/test_watchdog_interval_timer.sv ***
`timescale 1ns/1ps
`include "wit_defs.svh"
module test_watchdog_interval_timer;
    logic        clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, halt_i = 0, stop_i = 0, sub_i = 0;
    logic [3:0]  addr_i = 4'h0;
    logic [7:0]  wdata_i = 8'h00;
    wire  [7:0]  rdata_o, n_nmi, n_irq;
    wire  [2:0]  prio;
    wire         rst_o, nmi_o, irq_o, top_o;
    int          n_mismatch = 0, comparisons = 0, n;
    logic [11:0] rows [5] = '{12'h000, 12'h100, 12'h247, 12'h301, 12'h900};
    wit_top dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .halt_mode_i(halt_i), .stop_idle_mode_i(stop_i),
        .subclock_sel_i(sub_i), .wd_reset_request_o(rst_o), .wd_nmi_request_o(nmi_o),
        .interval_irq_request_o(irq_o), .interval_irq_priority_o(prio), .interval_irq_default_top_o(top_o));
    wit_sw_model sw_u (.clk_i(clk_i), .nrst_i(nrst_i), .nmi_i(nmi_o), .rst_i(rst_o), .irq_i(irq_o),
        .n_nmi_o(n_nmi), .n_irq_o(n_irq));
    initial forever #12.5 clk_i = ~clk_i;
    task report_and_stop;
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task idle(input int c);
        repeat (c) @(posedge clk_i);
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask
    // Count cycles until request s shows; s 0 interval, 1 nmi, 2 reset
    task wt(input int s, input int lo, input int hi);
        logic [2:0] r;
        n = 0;
        r = 3'b000;
        while (r[s] !== 1'b1) begin
            @(posedge clk_i);
            #1 n++;
            r = {rst_o, nmi_o, irq_o};
            if (n > hi) begin
                n_mismatch++;
                report_and_stop;
            end
        end
        chk(8'(n >= lo), 8'h01);
    endtask
    initial begin
        idle(10);
        nrst_i <= 1'b1;
        foreach (rows[i]) rd(rows[i][11:8], rows[i][7:0]);
        wr(`WIT_OFS_MODE, 8'h80);
        wr(`WIT_OFS_MODE, 8'h00);
        rd(`WIT_OFS_MODE, 8'h80);
        idle(8300);
        #1 chk(n_irq, 8'h00);
        rd(`WIT_OFS_STATUS, 8'h12);
        rd(`WIT_OFS_STATUS, 8'h02);
        wr(`WIT_OFS_IRQ_CTRL, 8'h03);
        #1 chk(8'(prio), 8'h03);
        halt_i <= 1'b1;
        wt(0, 1, 8192);
        idle(2000);
        sub_i <= 1'b1;
        idle(3000);
        sub_i <= 1'b0;
        wt(0, 6150, 6200);
        wr(`WIT_OFS_MODE, 8'h90);
        wr(`WIT_OFS_MODE, 8'h00);
        rd(`WIT_OFS_MODE, 8'h90);
        idle(6000);
        wr(`WIT_OFS_MODE, 8'h80);
        stop_i <= 1'b1;
        idle(10000);
        #1 chk(n_nmi, 8'h00);
        stop_i <= 1'b0;
        wt(1, 8150, 8200);
        chk(n_irq, 8'h02);
        nrst_i <= 1'b0;
        idle(3);
        nrst_i <= 1'b1;
        rd(`WIT_OFS_MODE, 8'h00);
        wr(`WIT_OFS_TIME, 8'h01);
        wr(`WIT_OFS_IRQ_CTRL, 8'h00);
        wr(`WIT_OFS_MODE, 8'h88);
        wt(0, 16350, 16400);
        idle(2);
        #1 chk(n_irq, 8'h01);
        chk(n_nmi, 8'h00);
        wr(`WIT_OFS_TIME, 8'h00);
        wr(`WIT_OFS_MODE, 8'h98);
        wt(2, 8150, 8200);
        report_and_stop;
    end
endmodule

// *** sim/wit_props.sv ***
`timescale 1ns/1ps
`include "wit_defs.svh"
module wit_props #(
    parameter int CNT_W = 21
) (
    input wire logic       clk_i,
    input wire logic       nrst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       halt_mode_i,
    input wire logic       stop_idle_mode_i,
    input wire logic       subclock_sel_i,
    input wire logic       wd_reset_request_o,
    input wire logic       wd_nmi_request_o,
    input wire logic       interval_irq_request_o,
    input wire logic [2:0] interval_irq_priority_o,
    input wire logic       interval_irq_default_top_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    logic wd_seen_q;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) wd_seen_q <= 1'b0;
        else if (wr_i && addr_i == `WIT_OFS_MODE && wdata_i[4]) wd_seen_q <= 1'b1;
    end
    sequence s_run_wr;
        wr_i && addr_i == `WIT_OFS_MODE && wdata_i[7];
    endsequence
    sequence s_quiet;
        !(wd_nmi_request_o || wd_reset_request_o || interval_irq_request_o);
    endsequence
    restart_quiet_a: assert property (s_run_wr |=> ##1 s_quiet [*8])
        else $error("request right after restart");
    no_interval_a: assert property (wd_seen_q |-> ##2 !interval_irq_request_o)
        else $error("interval request in watchdog mode");
    one_kind_a: assert property ($onehot0({wd_nmi_request_o, wd_reset_request_o, interval_irq_request_o}))
        else $error("two requests at once");
    nmi_pulse_a: assert property (wd_nmi_request_o |=> !wd_nmi_request_o)
        else $error("nmi request too long");
    rst_pulse_a: assert property ($rose(wd_reset_request_o) |=> $fell(wd_reset_request_o))
        else $error("reset request too long");
    prio_follow_a: assert property (wr_i && addr_i == `WIT_OFS_IRQ_CTRL |=>
        interval_irq_priority_o == $past(wdata_i[2:0]))
        else $error("priority not taken");
    top_prio_a: assert property (interval_irq_default_top_o)
        else $error("default priority not top");
    sub_hold_a: assert property (subclock_sel_i [*6] |-> s_quiet)
        else $error("request while on subclock");
    stop_hold_a: assert property (stop_idle_mode_i [*6] |-> s_quiet)
        else $error("request while stopped");
endmodule
bind wit_top wit_props #(.CNT_W(CNT_W)) props_u (.*);

// *** sim/wit_sw_model.sv ***
`timescale 1ns/1ps
module wit_sw_model (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       nmi_i,
    input  wire logic       rst_i,
    input  wire logic       irq_i,
    output logic      [7:0] n_nmi_o,
    output logic      [7:0] n_irq_o
);
    // Interrupt controller and reset logic: count each request taken
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            n_nmi_o <= 8'h00;
            n_irq_o <= 8'h00;
        end else begin
            n_nmi_o <= n_nmi_o + 8'(nmi_i || rst_i);
            n_irq_o <= n_irq_o + 8'(irq_i);
        end
    end
endmodule
